// ### include/dbm_pkg.sv
// Purpose: Shared constants and types for the DRAM bank decode and address mux.
// Assumes: One clock, configuration held steady by software while transfers run.
// Notes: Encodings of port width, page size and page mode are local choices.
//
// Operation
// [R1] Decode order: chip selects 0..7 first, then bank 0, then bank 1.
// [R2] No hit: default memory transfer, no chip select or DRAM strobes asserted.
// [R3] Each bank has read and write enables; disabled direction never reaches it.
// [R4] Four attribute mask bits per bank exclude masked transfer classes.
// [R5] Bank selected only on address match, enabled direction and unmasked class.
// [R6] One row/column strobe timing set shared by both banks.
// [R7] Normal mode gives row and column address every transfer.
// [R8] Fast page: row plus column first, then column only within the page.
// [R9] Burst page: normal unless operand wider than port, then fast page.
// [R10] Per bank port width 8/16/32 and page size 512/1K/2K bytes.
// [R11] Core transfers always multiplexed; external master only when enabled.
// [R12] Drive full internal address on pins 27..0, then assert row strobe.
// [R13] 8-bit/512: row bits 17..9, then bits 8..0 on pins 17..9, column strobe.
// [R14] Port width and page size choose pins for row and column bits.
// [R15] Four byte column strobes; low address bits unneeded on wide ports.
// [R16] Match address bits 31..17 with base, skipping masked bits.
// [R17] Other width/page combinations follow the matching pin assignment pattern.
package dbm_pkg;

  // ********************************************************
  // Widths and counts
  // ********************************************************
  localparam int ADDR_W = 32;
  localparam int PIN_W = 28;
  localparam int CMP_LO = 17;
  localparam int CMP_W = 15;
  localparam int NUM_CS = 8;
  localparam int NUM_BANK = 2;
  localparam int TIM_W = 4;
  localparam int COL_BASE_PIN = 9;

  // ********************************************************
  // Field encodings
  // ********************************************************
  localparam logic [1:0] PW_32 = 2'h0;
  localparam logic [1:0] PW_8 = 2'h1;
  localparam logic [1:0] PW_16 = 2'h2;
  localparam logic [1:0] PG_512 = 2'h0;
  localparam logic [1:0] PG_1K = 2'h1;
  localparam logic [1:0] PG_2K = 2'h2;
  localparam logic [1:0] PM_NORMAL = 2'h0;
  localparam logic [1:0] PM_FAST = 2'h1;
  localparam logic [1:0] PM_BURST = 2'h2;
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;
  // Attribute mask bit positions
  localparam int ATTR_UD = 0;
  localparam int ATTR_UC = 1;
  localparam int ATTR_SD = 2;
  localparam int ATTR_SC = 3;
  // Page compare masks
  localparam logic [31:0] PGMASK_512 = 32'hFFFF_FE00;
  localparam logic [31:0] PGMASK_1K = 32'hFFFF_FC00;
  localparam logic [31:0] PGMASK_2K = 32'hFFFF_F800;
  localparam logic [3:0] STROBE_OFF = 4'hF;
  localparam logic [1:0] BANK_OFF = 2'h3;

  // ********************************************************
  // Types
  // ********************************************************
  typedef struct packed {
    logic [CMP_W-1:0] base_addr_field;
    logic [CMP_W-1:0] base_addr_mask_field;
    logic [3:0] attr_mask;
    logic rd_en;
    logic wr_en;
    logic [1:0] port_width_field;
    logic [1:0] page_size_field;
    logic [1:0] page_mode;
  } dbm_bank_cfg_t;

  typedef struct packed {
    logic valid;
    logic [CMP_W-1:0] base_addr_field;
    logic [CMP_W-1:0] base_addr_mask_field;
  } dbm_cs_cfg_t;

  typedef struct packed {
    logic [TIM_W-1:0] ras_to_cas;
    logic [TIM_W-1:0] cas_width;
    logic [TIM_W-1:0] precharge;
    logic ext_mux_en;
  } dbm_timing_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic write;
    logic supv;
    logic code;
    logic [1:0] op_size;
    logic ext;
  } dbm_xfer_t;

  typedef struct packed {
    logic [NUM_CS-1:0] cs;
    logic [NUM_BANK-1:0] bank;
    logic dflt;
  } dbm_decode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ROW = 3'h1,
    ST_RCD = 3'h2,
    ST_CAS = 3'h3,
    ST_PAGE = 3'h4,
    ST_PRE = 3'h5,
    ST_NDRAM = 3'h6,
    ST_COL = 3'h7
  } dbm_state_t;

endpackage

// ### design/dbm_region_match.sv
// Purpose: Address window match with optional direction and attribute checks.
// Assumes: Configuration stable during the compare.
// Notes: Chip selects use it with CHECK_PERM off.
module dbm_region_match #(
  parameter bit CHECK_PERM = 1'b1
) (
  input wire logic [dbm_pkg::ADDR_W-1:0] addr,
  input wire logic [dbm_pkg::CMP_W-1:0] base,
  input wire logic [dbm_pkg::CMP_W-1:0] mask,
  input wire logic write,
  input wire logic supv,
  input wire logic code,
  input wire logic rd_en,
  input wire logic wr_en,
  input wire logic [3:0] attr_mask,
  output logic hit
);

  // ********************************************************
  // Compare
  // ********************************************************
  // Masked bits drop out, so an all-clear mask gives the smallest window
  wire logic [dbm_pkg::CMP_W-1:0] tag = addr[dbm_pkg::ADDR_W-1:dbm_pkg::CMP_LO];
  wire logic addr_ok = ((tag ^ base) & ~mask) == '0; // see [R16]
  wire logic dir_ok = write ? wr_en : rd_en; // see [R3]
  wire logic [1:0] cls = {supv, code};
  wire logic class_masked = (cls == 2'h0) ? attr_mask[dbm_pkg::ATTR_UD] :
                            (cls == 2'h1) ? attr_mask[dbm_pkg::ATTR_UC] :
                            (cls == 2'h2) ? attr_mask[dbm_pkg::ATTR_SD] :
                                            attr_mask[dbm_pkg::ATTR_SC]; // see [R4]

  // With CHECK_PERM set, all three terms must hold together; with it clear, only the address match counts
  assign hit = CHECK_PERM ? (addr_ok && dir_ok && !class_masked) : addr_ok; // see [R5]

endmodule

// ### design/dbm_dram_mux.sv
// Purpose: Transfer decode and row/column sequencing for two DRAM banks.
// Assumes: Bus controller holds xfer stable while xfer_valid is high.
// Notes: Refresh and chip select waveforms live outside this block.
module dbm_dram_mux (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic xfer_valid,
  input wire dbm_pkg::dbm_xfer_t xfer,
  output logic xfer_ready,
  output logic xfer_done,
  input wire dbm_pkg::dbm_cs_cfg_t cs_cfg [dbm_pkg::NUM_CS],
  input wire dbm_pkg::dbm_bank_cfg_t bank_cfg [dbm_pkg::NUM_BANK],
  input wire dbm_pkg::dbm_timing_t timing,
  output dbm_pkg::dbm_decode_t decode,
  output logic [dbm_pkg::PIN_W-1:0] addr_pins,
  output logic [dbm_pkg::NUM_BANK-1:0] ras_n,
  output logic [3:0] cas_n,
  output logic dram_write_n,
  output logic page_open
);

  // ********************************************************
  // Helpers
  // ********************************************************
  // Column pin map; pins below the column field repeat the row bit
  function automatic logic [dbm_pkg::PIN_W-1:0] col_map(
    input logic [dbm_pkg::PIN_W-1:0] ia,
    input logic [1:0] pw,
    input logic [1:0] pg
  );
    logic [dbm_pkg::PIN_W-1:0] r;
    int s;
    int base;
    int w;
    r = '0;
    s = (pw == dbm_pkg::PW_8) ? 0 : (pw == dbm_pkg::PW_16) ? 1 : 2; // see [R15]
    base = dbm_pkg::COL_BASE_PIN + int'(pg); // see [R10]
    w = base - s;
    for (int j = 0; j < dbm_pkg::PIN_W; j++) begin
      if (j < base) begin
        r[j] = ia[j];
      end else if (j < base + w) begin
        r[j] = ia[s + j - base]; // see [R13]
      end else if (pw == dbm_pkg::PW_16) begin
        r[j] = ia[(j - 1) | 1]; // see [R17]
      end else begin
        r[j] = ia[j & ~1]; // see [R17]
      end
    end
    return r; // see [R14]
  endfunction

  // Byte lanes on the top of the data bus, one strobe per lane
  function automatic logic [3:0] lanes(
    input logic [1:0] a,
    input logic [1:0] sz,
    input logic [1:0] pw
  );
    logic [3:0] l;
    l = 4'h8;
    if (pw == dbm_pkg::PW_16) begin
      l = (sz == dbm_pkg::SZ_BYTE) ? (a[0] ? 4'h4 : 4'h8) : 4'hC;
    end else if (pw == dbm_pkg::PW_32) begin
      if (sz == dbm_pkg::SZ_BYTE) begin
        l = 4'h8 >> a;
      end else if (sz == dbm_pkg::SZ_WORD) begin
        l = a[1] ? 4'h3 : 4'hC;
      end else begin
        l = 4'hF;
      end
    end
    return l; // see [R15]
  endfunction

  function automatic logic [dbm_pkg::TIM_W-1:0] cyc(input logic [dbm_pkg::TIM_W-1:0] v);
    return (v == '0) ? dbm_pkg::TIM_W'(1) : v;
  endfunction

  // ********************************************************
  // Region matchers
  // ********************************************************
  logic [dbm_pkg::NUM_CS-1:0] cs_hit;
  logic [dbm_pkg::NUM_BANK-1:0] bk_hit;

  for (genvar i = 0; i < dbm_pkg::NUM_CS; i++) begin : g_cs
    logic raw;
    dbm_region_match #(.CHECK_PERM(1'b0)) u_cs (
      .addr(xfer.addr),
      .base(cs_cfg[i].base_addr_field),
      .mask(cs_cfg[i].base_addr_mask_field),
      .write(xfer.write),
      .supv(xfer.supv),
      .code(xfer.code),
      .rd_en(1'b1),
      .wr_en(1'b1),
      .attr_mask(4'h0),
      .hit(raw)
    );
    assign cs_hit[i] = raw && cs_cfg[i].valid;
  end

  for (genvar b = 0; b < dbm_pkg::NUM_BANK; b++) begin : g_bank
    dbm_region_match #(.CHECK_PERM(1'b1)) u_bank (
      .addr(xfer.addr),
      .base(bank_cfg[b].base_addr_field),
      .mask(bank_cfg[b].base_addr_mask_field),
      .write(xfer.write),
      .supv(xfer.supv),
      .code(xfer.code),
      .rd_en(bank_cfg[b].rd_en),
      .wr_en(bank_cfg[b].wr_en),
      .attr_mask(bank_cfg[b].attr_mask),
      .hit(bk_hit[b])
    );
  end

  // ********************************************************
  // Priority decode
  // ********************************************************
  // Lowest set bit wins, so chip select 0 outranks 7
  wire logic [dbm_pkg::NUM_CS-1:0] cs_first = cs_hit & (~cs_hit + 8'h01); // see [R1]
  wire logic any_cs = |cs_hit;
  wire logic [1:0] bank_pick = any_cs ? 2'h0 : bk_hit[0] ? 2'h1 : {bk_hit[1], 1'b0}; // see [R1]
  wire dbm_pkg::dbm_decode_t dec_w = '{cs: cs_first, bank: bank_pick,
                                      dflt: !any_cs && (bk_hit == '0)}; // see [R2]
  wire logic new_bank = bank_pick[1];
  wire dbm_pkg::dbm_bank_cfg_t ncfg = bank_cfg[new_bank];
  wire logic new_dram = |bank_pick;

  // ********************************************************
  // State and registers
  // ********************************************************
  dbm_pkg::dbm_state_t state_q, state_d;
  dbm_pkg::dbm_xfer_t xfer_q, xfer_d;
  dbm_pkg::dbm_decode_t dec_q, dec_d;
  logic bank_q, bank_d;
  logic pend_q, pend_d;
  logic [dbm_pkg::TIM_W-1:0] cnt_q, cnt_d;
  logic [dbm_pkg::ADDR_W-1:0] open_addr_q, open_addr_d;
  logic [dbm_pkg::PIN_W-1:0] addr_q, addr_d;
  logic [1:0] ras_q, ras_d;
  logic [3:0] cas_q, cas_d;
  logic wr_n_q, wr_n_d;
  logic done_q, done_d;

  wire dbm_pkg::dbm_bank_cfg_t ccfg = bank_cfg[bank_q];
  wire logic [31:0] pg_mask = (ncfg.page_size_field == dbm_pkg::PG_2K) ? dbm_pkg::PGMASK_2K :
                              (ncfg.page_size_field == dbm_pkg::PG_1K) ? dbm_pkg::PGMASK_1K :
                                                                         dbm_pkg::PGMASK_512;
  wire logic page_hit = (state_q == dbm_pkg::ST_PAGE) && new_dram && (new_bank == bank_q) &&
                        (((xfer.addr ^ open_addr_q) & pg_mask) == '0); // see [R8]
  // Operand wider than port means the bus controller bursts beats
  wire logic burst_xfer = xfer_q.op_size > ((ccfg.port_width_field == dbm_pkg::PW_32) ? 2'h2 :
                          (ccfg.port_width_field == dbm_pkg::PW_16) ? 2'h1 : 2'h0);
  wire logic keep_open = (ccfg.page_mode == dbm_pkg::PM_FAST) ||
                         ((ccfg.page_mode == dbm_pkg::PM_BURST) && burst_xfer); // see [R9]
  wire logic use_mux = !xfer_q.ext || timing.ext_mux_en; // see [R11]
  wire logic new_mux = !xfer.ext || timing.ext_mux_en; // see [R11]
  wire logic [dbm_pkg::PIN_W-1:0] col_latched = use_mux ?
      col_map(xfer_q.addr[dbm_pkg::PIN_W-1:0], ccfg.port_width_field, ccfg.page_size_field) :
      xfer_q.addr[dbm_pkg::PIN_W-1:0];
  wire logic [dbm_pkg::PIN_W-1:0] col_new = new_mux ?
      col_map(xfer.addr[dbm_pkg::PIN_W-1:0], ncfg.port_width_field, ncfg.page_size_field) :
      xfer.addr[dbm_pkg::PIN_W-1:0];

  assign xfer_ready = (state_q == dbm_pkg::ST_IDLE) || (state_q == dbm_pkg::ST_PAGE);

  // Next state; one timing set serves both banks
  always_comb begin
    state_d = state_q;
    xfer_d = xfer_q;
    dec_d = dec_q;
    bank_d = bank_q;
    pend_d = pend_q;
    cnt_d = cnt_q;
    open_addr_d = open_addr_q;
    addr_d = addr_q;
    ras_d = ras_q;
    cas_d = cas_q;
    wr_n_d = wr_n_q;
    done_d = 1'b0;
    case (state_q)
      dbm_pkg::ST_IDLE, dbm_pkg::ST_PAGE: begin
        if (xfer_valid) begin
          xfer_d = xfer;
          dec_d = dec_w;
          if (page_hit) begin
            addr_d = col_new; // see [R8]
            wr_n_d = !xfer.write;
            state_d = dbm_pkg::ST_COL;
          end else if (state_q == dbm_pkg::ST_PAGE) begin
            // Close the old page before anything else runs
            ras_d = dbm_pkg::BANK_OFF;
            cnt_d = cyc(timing.precharge); // see [R6]
            pend_d = 1'b1;
            state_d = dbm_pkg::ST_PRE;
          end else if (new_dram) begin
            bank_d = new_bank;
            addr_d = xfer.addr[dbm_pkg::PIN_W-1:0]; // see [R12]
            wr_n_d = !xfer.write;
            state_d = dbm_pkg::ST_ROW;
          end else begin
            state_d = dbm_pkg::ST_NDRAM; // see [R2]
          end
        end
      end
      dbm_pkg::ST_NDRAM: begin
        done_d = 1'b1;
        state_d = dbm_pkg::ST_IDLE;
      end
      dbm_pkg::ST_ROW: begin
        ras_d[bank_q] = 1'b0; // see [R12]
        cnt_d = cyc(timing.ras_to_cas); // see [R6]
        open_addr_d = xfer_q.addr;
        state_d = dbm_pkg::ST_RCD;
      end
      dbm_pkg::ST_RCD: begin
        if (cnt_q <= dbm_pkg::TIM_W'(1)) begin
          addr_d = col_latched; // see [R7]
          state_d = dbm_pkg::ST_COL;
        end else begin
          cnt_d = cnt_q - dbm_pkg::TIM_W'(1);
        end
      end
      dbm_pkg::ST_COL: begin
        cas_d = ~lanes(xfer_q.addr[1:0], xfer_q.op_size, ccfg.port_width_field); // see [R15]
        cnt_d = cyc(timing.cas_width); // see [R6]
        state_d = dbm_pkg::ST_CAS;
      end
      dbm_pkg::ST_CAS: begin
        if (cnt_q <= dbm_pkg::TIM_W'(1)) begin
          cas_d = dbm_pkg::STROBE_OFF;
          wr_n_d = 1'b1;
          done_d = 1'b1;
          if (keep_open) begin
            state_d = dbm_pkg::ST_PAGE; // see [R8]
          end else begin
            ras_d = dbm_pkg::BANK_OFF; // see [R7]
            cnt_d = cyc(timing.precharge);
            state_d = dbm_pkg::ST_PRE;
          end
        end else begin
          cnt_d = cnt_q - dbm_pkg::TIM_W'(1);
        end
      end
      dbm_pkg::ST_PRE: begin
        if (cnt_q > dbm_pkg::TIM_W'(1)) begin
          cnt_d = cnt_q - dbm_pkg::TIM_W'(1);
        end else if (!pend_q) begin
          state_d = dbm_pkg::ST_IDLE;
        end else begin
          pend_d = 1'b0;
          if (|dec_q.bank) begin
            bank_d = dec_q.bank[1];
            addr_d = xfer_q.addr[dbm_pkg::PIN_W-1:0]; // see [R12]
            wr_n_d = !xfer_q.write;
            state_d = dbm_pkg::ST_ROW;
          end else begin
            state_d = dbm_pkg::ST_NDRAM; // see [R2]
          end
        end
      end
      default: begin
        state_d = dbm_pkg::ST_IDLE;
      end
    endcase
  end

  // Register file of the sequencer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= dbm_pkg::ST_IDLE;
      xfer_q <= '0;
      dec_q <= '0;
      bank_q <= 1'b0;
      pend_q <= 1'b0;
      cnt_q <= '0;
      open_addr_q <= '0;
      addr_q <= '0;
      ras_q <= dbm_pkg::BANK_OFF;
      cas_q <= dbm_pkg::STROBE_OFF;
      wr_n_q <= 1'b1;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      xfer_q <= xfer_d;
      dec_q <= dec_d;
      bank_q <= bank_d;
      pend_q <= pend_d;
      cnt_q <= cnt_d;
      open_addr_q <= open_addr_d;
      addr_q <= addr_d;
      ras_q <= ras_d;
      cas_q <= cas_d;
      wr_n_q <= wr_n_d;
      done_q <= done_d;
    end
  end

  // Outputs straight from flip-flops, except page_open and xfer_ready, which are decoded from state_q
  assign decode = dec_q;
  assign addr_pins = addr_q;
  assign ras_n = ras_q;
  assign cas_n = cas_q;
  assign dram_write_n = wr_n_q;
  assign xfer_done = done_q;
  assign page_open = (state_q == dbm_pkg::ST_PAGE);

  // ********************************************************
  // Checks
  // ********************************************************
  wire logic accept = xfer_valid && xfer_ready;
  sequence s_row_setup;
    state_q == dbm_pkg::ST_ROW && ras_n == dbm_pkg::BANK_OFF;
  endsequence
  sequence s_row_strobe;
    ras_n != dbm_pkg::BANK_OFF && addr_pins == xfer_q.addr[dbm_pkg::PIN_W-1:0];
  endsequence

  AST_CS_FIRST: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R1]
    accept && cs_hit[0] |=> decode.cs == 8'h01 && decode.bank == 2'h0)
    else $error("chip select 0 did not win decode");
  // Chip select transfers pass the same quiet state
  AST_DFLT_QUIET: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R2]
    state_q == dbm_pkg::ST_NDRAM |-> ras_n == dbm_pkg::BANK_OFF &&
      cas_n == dbm_pkg::STROBE_OFF && (decode.dflt || decode.cs != '0))
    else $error("strobe active during default memory transfer");
  AST_WR_BLOCK: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R3]
    accept && xfer.write && !bank_cfg[0].wr_en |=> !decode.bank[0])
    else $error("write reached a bank without write enable");
  AST_ATTR_BLOCK: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R4]
    accept && bank_cfg[0].attr_mask[{xfer.supv, xfer.code}]
    |=> !decode.bank[0])
    else $error("masked attribute class reached bank 0");
  AST_ROW_FIRST: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R12]
    s_row_setup |=> s_row_strobe)
    else $error("row strobe without full address on pins");
  AST_COL_ADDR: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R14]
    $fell(cas_n[3]) && use_mux && xfer_q.addr[1:0] == 2'h0 |->
      addr_pins == col_map(xfer_q.addr[dbm_pkg::PIN_W-1:0], ccfg.port_width_field,
                           ccfg.page_size_field))
    else $error("column strobe with wrong column address");
  AST_PAGE_HIT: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R8]
    accept && page_hit |=> state_q == dbm_pkg::ST_COL && ras_n != dbm_pkg::BANK_OFF)
    else $error("page hit reopened the row");
  AST_NORMAL_CLOSE: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R7]
    state_q == dbm_pkg::ST_CAS && state_d != dbm_pkg::ST_CAS &&
    ccfg.page_mode == dbm_pkg::PM_NORMAL |=> ras_n == dbm_pkg::BANK_OFF && xfer_done)
    else $error("normal mode left the row open");
  AST_CAS_AFTER_RAS: assert property (@(posedge ref_clk) disable iff (!rst_n) // see [R6]
    $fell(ras_n[0]) |-> cas_n == dbm_pkg::STROBE_OFF ##1 cas_n == dbm_pkg::STROBE_OFF)
    else $error("column strobe too soon after row strobe");

endmodule

// ### tb/dbm_dram_model.sv
// Purpose: DRAM stand-in that latches row, column and lane strobes.
// Assumes: Strobes come from registers, so they never glitch.
// Notes: Holds no data; it only records what the pins carried.
module dbm_dram_model (
  input wire logic [dbm_pkg::PIN_W-1:0] addr_pins,
  input wire logic [1:0] ras_n,
  input wire logic [3:0] cas_n,
  input wire logic dram_write_n,
  output logic [dbm_pkg::PIN_W-1:0] row_q,
  output logic [dbm_pkg::PIN_W-1:0] col_q,
  output logic [3:0] lane_q,
  output logic wr_q,
  output int ras_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic cas_any;

  // ****************
  // Address latches
  // ****************
  assign cas_any = ~&cas_n;
  initial begin
    row_q = '0;
    col_q = '0;
    lane_q = 4'hF;
    wr_q = 1'b1;
    ras_cnt = 0;
  end
  // Row taken as the strobe falls, as a real part would
  always @(negedge ras_n[0] or negedge ras_n[1]) begin
    row_q = addr_pins;
    ras_cnt = ras_cnt + 1;
  end
  // Any byte lane opens the column phase
  always @(posedge cas_any) begin
    col_q = addr_pins;
    lane_q = cas_n;
    wr_q = dram_write_n;
  end
endmodule

// ### tb/dram_bank_decode_and_mux_bench.sv
// Purpose: Directed bench for decode priority, permissions and address muxing.
// Assumes: Configuration only changes between transfers.
// Notes: Page tests run last so no open page overlaps a default transfer.
module dram_bank_decode_and_mux_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst_n, xfer_valid, xfer_ready, xfer_done, dram_write_n, page_open, wr_q;
  dbm_pkg::dbm_xfer_t xfer;
  dbm_pkg::dbm_cs_cfg_t cs_cfg [dbm_pkg::NUM_CS];
  dbm_pkg::dbm_bank_cfg_t bank_cfg [dbm_pkg::NUM_BANK];
  dbm_pkg::dbm_timing_t timing;
  dbm_pkg::dbm_decode_t decode;
  logic [27:0] addr_pins, row_q, col_q;
  logic [1:0] ras_n;
  logic [3:0] cas_n, lane_q;
  int ras_cnt, errors, cmp_count, lat, r0, strobe_hits;

  // ****************
  // Design and far side
  // ****************
  dbm_dram_mux u_dbm_dram_mux (.ref_clk(ref_clk), .rst_n(rst_n), .xfer_valid(xfer_valid),
    .xfer(xfer), .xfer_ready(xfer_ready), .xfer_done(xfer_done), .cs_cfg(cs_cfg),
    .bank_cfg(bank_cfg), .timing(timing), .decode(decode), .addr_pins(addr_pins),
    .ras_n(ras_n), .cas_n(cas_n), .dram_write_n(dram_write_n), .page_open(page_open));
  dbm_dram_model u_dbm_dram_model (.addr_pins(addr_pins), .ras_n(ras_n), .cas_n(cas_n),
    .dram_write_n(dram_write_n), .row_q(row_q), .col_q(col_q), .lane_q(lane_q), .wr_q(wr_q),
    .ras_cnt(ras_cnt));

  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Any strobe while a default transfer is decoded is a fault
  always @(posedge ref_clk) begin
    if (decode.dflt === 1'b1 && (ras_n !== 2'h3 || cas_n !== 4'hF)) strobe_hits++;
  end

  // ****************
  // Tasks
  // ****************
  task automatic end_sim();
    if (errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (exp !== got) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One request, held until taken; lat counts falling edges to done
  task automatic do_xfer(input logic [31:0] a, input logic w, input logic s, input logic c,
                         input logic [1:0] sz, input logic e);
    int n;
    @(negedge ref_clk);
    xfer = {a, w, s, c, sz, e};
    xfer_valid = 1'b1;
    n = 0;
    while (xfer_ready !== 1'b1 && n < 50) begin
      @(negedge ref_clk);
      n++;
    end
    @(negedge ref_clk);
    xfer_valid = 1'b0;
    lat = 1;
    while (xfer_done !== 1'b1 && lat < 60) begin
      @(negedge ref_clk);
      lat++;
    end
    if (n >= 50 || lat >= 60) begin
      errors++;
      end_sim();
    end
  endtask

  // ****************
  // Main sequence
  // ****************
  initial begin
    errors = 0;
    cmp_count = 0;
    strobe_hits = 0;
    rst_n = 1'b0;
    xfer_valid = 1'b0;
    xfer = '0;
    foreach (cs_cfg[i]) cs_cfg[i] = '0;
    bank_cfg[0] = '{15'h200, 15'h0, 4'h0, 1'b1, 1'b0, dbm_pkg::PW_8, dbm_pkg::PG_512,
                    dbm_pkg::PM_NORMAL};
    bank_cfg[1] = '{15'h280, 15'h0, 4'h0, 1'b1, 1'b1, dbm_pkg::PW_8, dbm_pkg::PG_1K,
                    dbm_pkg::PM_NORMAL};
    timing = '{4'h2, 4'h1, 4'h1, 1'b0};
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_n = 1'b1;
    // Core read, 8-bit 512-byte bank 0: full address then column on 17..9
    // Done shows at the sixth falling edge with two row-to-column cycles
    do_xfer(32'h0400_0A5C, 1'b0, 1'b1, 1'b0, dbm_pkg::SZ_BYTE, 1'b0);
    chk("decode", 32'h002, decode);
    chk("row", 32'h400_0A5C, row_q);
    chk("col", 32'h05C, col_q[17:9]);
    chk("lane", 32'h7, lane_q);
    chk("wr_rd", 32'h1, wr_q);
    chk("lat0", 32'h6, lat);
    chk("ras_closed", 32'h3, ras_n);
    // Bank 1 at 1K pages: column on 19..10, same timing
    do_xfer(32'h0500_1357, 1'b1, 1'b1, 1'b0, dbm_pkg::SZ_BYTE, 1'b0);
    chk("decode", 32'h004, decode);
    chk("col1k", 32'h357, col_q[19:10]);
    chk("wr_wr", 32'h0, wr_q);
    chk("lat1", 32'h6, lat);
    // Write to a read-only bank falls to default
    do_xfer(32'h0400_0000, 1'b1, 1'b1, 1'b0, dbm_pkg::SZ_BYTE, 1'b0);
    chk("decode", 32'h001, decode);
    chk("lat_dflt", 32'h2, lat);
    // User data masked, user code still allowed
    bank_cfg[0].attr_mask = 4'h1;
    do_xfer(32'h0400_0000, 1'b0, 1'b0, 1'b0, dbm_pkg::SZ_BYTE, 1'b0);
    chk("decode", 32'h001, decode);
    do_xfer(32'h0400_0000, 1'b0, 1'b0, 1'b1, dbm_pkg::SZ_BYTE, 1'b0);
    chk("decode", 32'h002, decode);
    // Chip selects open from 7 down; the lowest index must always win
    for (int i = 7; i >= 0; i--) begin
      cs_cfg[i] = '{1'b1, 15'h200, 15'h0};
      do_xfer(32'h0400_0000, 1'b0, 1'b1, 1'b0, dbm_pkg::SZ_BYTE, 1'b0);
      chk("decode_cs", 32'h8 << i, decode);
    end
    foreach (cs_cfg[i]) cs_cfg[i] = '0;
    // Overlapping banks: bank 0 ahead of bank 1
    bank_cfg[1].base_addr_field = 15'h200;
    do_xfer(32'h0400_0000, 1'b0, 1'b1, 1'b0, dbm_pkg::SZ_BYTE, 1'b0);
    chk("decode", 32'h002, decode);
    bank_cfg[1].base_addr_field = 15'h280;
    // No region at all
    do_xfer(32'h1000_0000, 1'b0, 1'b1, 1'b0, dbm_pkg::SZ_BYTE, 1'b0);
    chk("decode", 32'h001, decode);
    // External master: muxing only when enabled
    do_xfer(32'h0400_0123, 1'b0, 1'b1, 1'b0, dbm_pkg::SZ_BYTE, 1'b1);
    chk("col_ext", 32'h400_0123, col_q);
    timing.ext_mux_en = 1'b1;
    do_xfer(32'h0400_0123, 1'b0, 1'b1, 1'b0, dbm_pkg::SZ_BYTE, 1'b1);
    chk("col_extmux", 32'h123, col_q[17:9]);
    // 16-bit port, 2K page: word on the two top lanes, column bits 10..1 on 20..11
    bank_cfg[1].port_width_field = dbm_pkg::PW_16;
    bank_cfg[1].page_size_field = dbm_pkg::PG_2K;
    do_xfer(32'h0500_0ABC, 1'b0, 1'b1, 1'b0, dbm_pkg::SZ_WORD, 1'b0);
    chk("decode", 32'h004, decode);
    chk("col16_2k", 32'h15E, col_q[20:11]);
    chk("lane16", 32'h3, lane_q);
    bank_cfg[1].port_width_field = dbm_pkg::PW_8;
    bank_cfg[1].page_size_field = dbm_pkg::PG_1K;
    // Fast page: one row strobe per page
    bank_cfg[0].page_mode = dbm_pkg::PM_FAST;
    r0 = ras_cnt;
    do_xfer(32'h0400_0010, 1'b0, 1'b1, 1'b0, dbm_pkg::SZ_BYTE, 1'b0);
    do_xfer(32'h0400_0024, 1'b0, 1'b1, 1'b0, dbm_pkg::SZ_BYTE, 1'b0);
    chk("ras_hit", 32'h1, ras_cnt - r0);
    chk("col_hit", 32'h024, col_q[17:9]);
    chk("page_open", 32'h1, page_open);
    do_xfer(32'h0400_0400, 1'b0, 1'b1, 1'b0, dbm_pkg::SZ_BYTE, 1'b0);
    chk("ras_miss", 32'h2, ras_cnt - r0);
    chk("row_miss", 32'h400_0400, row_q);
    // Burst mode: normal for a byte, page held for a long on 8 bits
    bank_cfg[1].page_mode = dbm_pkg::PM_BURST;
    do_xfer(32'h0500_0000, 1'b0, 1'b1, 1'b0, dbm_pkg::SZ_BYTE, 1'b0);
    chk("burst_byte", 32'h0, page_open);
    do_xfer(32'h0500_0000, 1'b0, 1'b1, 1'b0, dbm_pkg::SZ_LONG, 1'b0);
    chk("burst_long", 32'h1, page_open);
    chk("dflt_strobes", 32'h0, strobe_hits);
    end_sim();
  end
endmodule
